// *** rtl/tim_pkg.sv ***
// Package for the capture/compare timer core: register map, field layout, reset values.
// Assumes one AHB-Lite slave with 32-bit data and one word per register.
package tim_pkg;
    localparam int unsigned NUM_CH = 8;
    localparam logic [7:0] OFF_CHANNEL_MODE = 8'h80;
    localparam logic [7:0] OFF_FORCE = 8'h81;
    localparam logic [7:0] OFF_CH7_MASK = 8'h82;
    localparam logic [7:0] OFF_CH7_DATA = 8'h83;
    localparam logic [7:0] OFF_COUNT = 8'h84;
    localparam logic [7:0] OFF_CONTROL = 8'h86;
    localparam logic [7:0] OFF_PRESCALE = 8'h8D;
    localparam logic [7:0] OFF_OUT_MODE = 8'h88;
    localparam logic [7:0] OFF_OUT_LEVEL = 8'h89;
    localparam logic [7:0] OFF_EDGE_HIGH = 8'h8A;
    localparam logic [7:0] OFF_EDGE_LOW = 8'h8B;
    localparam logic [7:0] OFF_FLAGS = 8'h8E;
    localparam logic [7:0] OFF_WRAP = 8'h8F;
    localparam logic [7:0] OFF_PORT = 8'hAE;
    localparam logic [7:0] OFF_DIRECTION = 8'hAF;
    localparam logic [7:0] OFF_CHAN_BASE = 8'h90;
    localparam int unsigned CTRL_TIMER_ON = 7;
    localparam int unsigned WRAP_FLAG_BIT = 7;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [2:0] PRESCALE_RESET = 3'h0;
    localparam logic [5:0] ACC_DIV_LAST = 6'h3F;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    typedef struct packed {
        logic sel;
        logic write;
        logic [7:0] index;
    } bus_req_t;

    typedef struct packed {
        logic [7:0] value;
        logic [7:0] enable;
    } port_drive_t;
endpackage

// *** rtl/timer_capture_compare_core.sv ***
// Capture/compare timer: 16-bit counter behind a prescaler, eight capture/compare channels,
// AHB-Lite register slave. Register index = word address (haddr[9:2]).
// Assumes timer port pins are synchronous to core_clk and resolved by the caller.
// Behaviour
// - Mode bit 0 makes a channel capture, 1 makes it compare.
// - Writing a force bit performs that channel's compare action at once.
// - A forced action never sets the channel event flag.
// - Force register reads zero; writable any time.
// - Mask bit on a compare channel drives the pin; direction bit unchanged.
// - Channel 7 match copies masked channel 7 data bits onto the port.
// - Channel 7 data wins over a lower channel action in the same cycle.
// - Counter writes only take effect while the special mode flag is zero.
// - Counter writes do not reset the prescaler.
// - Whole 16-bit counter access completes in one cycle.
// - Timer on cleared stops counter and channels; set lets it run.
// - Divide-by-64 accumulator clock comes from core_clk through its own divider, not the prescale code, absent when timer off.
// - Enabled compare output overrides the pin's direction bit.
// - Port writes to a pin used by the timer are only latched.
// - Pins are general-purpose until a timer function uses them.
// - One 16-bit counter with prescaler and eight 16-bit channels.
// - Output code 00 off, 01 toggle, 10 low, 11 high.
// - Edge code 00 off, 01 rising, 10 falling, 11 both.
// - Counter wrap from all ones to zero sets the wrap flag.
`timescale 1ns/10ps
module timer_capture_compare_core
    import tim_pkg::*;
#(
    parameter int unsigned CH = tim_pkg::NUM_CH
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Mode strap: zero means special mode
    input wire logic special_mode_flag,
    // Timer port pins
    input wire logic [7:0] timer_port_in,
    output logic [7:0] timer_port_out,
    output logic [7:0] timer_port_oe,
    // Divided clock for the pulse accumulator
    output logic acc_tick
);
    import tim_pkg::*;

    bus_req_t req;
    logic [15:0] free_running_count;
    logic [7:0] channel_mode_bits;
    logic [7:0] ch7_pin_mask;
    logic [7:0] ch7_pin_data;
    logic [7:0] output_mode_bit;
    logic [7:0] output_level_bit;
    logic [7:0] edge_select_high;
    logic [7:0] edge_select_low;
    logic [7:0] channel_event_flag;
    logic counter_wrap_flag;
    logic timer_on;
    logic [2:0] prescale_sel;
    logic [4:0] prescale_cnt;
    logic [5:0] acc_div;
    logic [7:0] timer_port;
    logic [7:0] timer_port_direction;
    logic [7:0] comp_out;
    logic [7:0] pin_prev;
    logic [15:0] channel_value [CH];

    // Decode
    wire wr = req.sel & req.write;
    wire [7:0] wdat = hwdata[7:0];
    wire [15:0] wword = hwdata[15:0];
    wire take = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    wire [7:0] idx = haddr[9:2];
    wire wr_count = wr && req.index == OFF_COUNT && !special_mode_flag;
    wire [7:0] force_bits = (wr && req.index == OFF_FORCE) ? wdat : 8'h00;
    wire [7:0] oc_enable = output_mode_bit | output_level_bit;

    // Write strobe for one register index, valid during the data phase
    function automatic logic hit(input bus_req_t r, input logic [7:0] i);
        hit = r.sel && r.write && r.index == i;
    endfunction

    wire wr_mode = hit(req, OFF_CHANNEL_MODE);
    wire wr_mask = hit(req, OFF_CH7_MASK);
    wire wr_data = hit(req, OFF_CH7_DATA);
    wire wr_omode = hit(req, OFF_OUT_MODE);
    wire wr_olevel = hit(req, OFF_OUT_LEVEL);
    wire wr_edge_hi = hit(req, OFF_EDGE_HIGH);
    wire wr_edge_lo = hit(req, OFF_EDGE_LOW);
    wire wr_ctrl = hit(req, OFF_CONTROL);
    wire wr_pre = hit(req, OFF_PRESCALE);
    wire wr_port = hit(req, OFF_PORT);
    wire wr_dir = hit(req, OFF_DIRECTION);

    // Limitation: a new prescale code applies on the next clock, not at the
    // next all-zero prescaler edge; software should change it with the timer off.
    // The prescaler runs freely while the timer is on, so a counter write
    // only shortens the first count period.
    // Prescaler: factor 2^sel; sel 6 and 7 are reserved and behave as 32
    wire [4:0] pre_mask = (prescale_sel > 3'h5) ? 5'h1F : 5'((6'h01 << prescale_sel) - 6'h01);
    wire tick = timer_on && ((prescale_cnt & pre_mask) == 5'h00);
    wire [15:0] count_next = free_running_count + 16'h0001;
    wire wrap = tick && (free_running_count == 16'hFFFF);

    // Compare matches only on counter ticks
    logic [7:0] match;
    logic [7:0] cap_edge;
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            match[i] = tick && channel_mode_bits[i] && channel_value[i] == free_running_count;
            cap_edge[i] = timer_on && !channel_mode_bits[i] &&
                ((edge_select_low[i] && timer_port_in[i] && !pin_prev[i]) ||
                 (edge_select_high[i] && !timer_port_in[i] && pin_prev[i]));
        end
    end

    // Per-channel compare action forced action identical to a match
    function automatic logic act(input logic m, input logic l, input logic cur);
        act = m ? l : ~cur;
    endfunction

    logic [7:0] next_comp_out;
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            next_comp_out[i] = comp_out[i];
            if ((match[i] || force_bits[i]) && oc_enable[i])
                next_comp_out[i] = act(output_mode_bit[i], output_level_bit[i], comp_out[i]);
            if ((match[7] || force_bits[7]) && ch7_pin_mask[i] && channel_mode_bits[i])
                next_comp_out[i] = ch7_pin_data[i];
        end
    end

    // Timer owns a pin when its compare output or channel 7 mask is active
    wire [7:0] owned = channel_mode_bits & (oc_enable | ch7_pin_mask);
    wire [7:0] next_oe = owned | timer_port_direction;
    wire [7:0] next_pin = (owned & comp_out) | (~owned & timer_port);

    // Read mux
    logic [31:0] rd;
    always_comb
    begin
        rd = 32'h0000_0000;
        unique case (idx)
            OFF_CHANNEL_MODE: rd[7:0] = channel_mode_bits;
            OFF_FORCE: rd[7:0] = 8'h00;
            OFF_CH7_MASK: rd[7:0] = ch7_pin_mask;
            OFF_CH7_DATA: rd[7:0] = ch7_pin_data;
            OFF_COUNT: rd[15:0] = free_running_count;
            OFF_CONTROL: rd[CTRL_TIMER_ON] = timer_on;
            OFF_PRESCALE: rd[2:0] = prescale_sel;
            OFF_OUT_MODE: rd[7:0] = output_mode_bit;
            OFF_OUT_LEVEL: rd[7:0] = output_level_bit;
            OFF_EDGE_HIGH: rd[7:0] = edge_select_high;
            OFF_EDGE_LOW: rd[7:0] = edge_select_low;
            OFF_FLAGS: rd[7:0] = channel_event_flag;
            OFF_WRAP: rd[WRAP_FLAG_BIT] = counter_wrap_flag;
            OFF_PORT: rd[7:0] = timer_port_in;
            OFF_DIRECTION: rd[7:0] = timer_port_direction;
            default:
                if (idx[7:3] == OFF_CHAN_BASE[7:3])
                    rd[15:0] = channel_value[idx[2:0]];
        endcase
    end

    // Bus pipeline: zero wait states, always OKAY
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            req <= '0;
        else
            req <= '{sel: take, write: hwrite, index: idx};
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hrdata <= (take && !hwrite) ? rd : hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Control registers, one short process each
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            channel_mode_bits <= BYTE_RESET;
        else if (wr_mode)
            channel_mode_bits <= wdat;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            ch7_pin_mask <= BYTE_RESET;
        else if (wr_mask)
            ch7_pin_mask <= wdat;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            ch7_pin_data <= BYTE_RESET;
        else if (wr_data)
            ch7_pin_data <= wdat;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            output_mode_bit <= BYTE_RESET;
        else if (wr_omode)
            output_mode_bit <= wdat;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            output_level_bit <= BYTE_RESET;
        else if (wr_olevel)
            output_level_bit <= wdat;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            edge_select_high <= BYTE_RESET;
        else if (wr_edge_hi)
            edge_select_high <= wdat;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            edge_select_low <= BYTE_RESET;
        else if (wr_edge_lo)
            edge_select_low <= wdat;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            timer_on <= 1'b0;
        else if (wr_ctrl)
            timer_on <= wdat[CTRL_TIMER_ON];
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            prescale_sel <= PRESCALE_RESET;
        else if (wr_pre)
            prescale_sel <= wdat[2:0];
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            timer_port <= BYTE_RESET;
        else if (wr_port)
            timer_port <= wdat;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            timer_port_direction <= BYTE_RESET;
        else if (wr_dir)
            timer_port_direction <= wdat;
    end

    // Prescaler and accumulator divider run only while the timer is on
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            prescale_cnt <= 5'h00;
            acc_div <= 6'h00;
        end
        else if (timer_on)
        begin
            prescale_cnt <= prescale_cnt + 5'h01;
            acc_div <= acc_div + 6'h01;
        end
    end

    // Counter; a counter write leaves the prescaler alone
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            free_running_count <= COUNT_RESET;
        else if (wr_count)
            free_running_count <= wword;
        else if (tick)
            free_running_count <= count_next;
    end

    // Flags: hardware set wins over a write-one clear
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            channel_event_flag <= BYTE_RESET;
            counter_wrap_flag <= 1'b0;
        end
        else
        begin
            channel_event_flag <= (channel_event_flag &
                ~((wr && req.index == OFF_FLAGS) ? wdat : 8'h00)) | match | cap_edge;
            counter_wrap_flag <= (counter_wrap_flag &
                ~(wr && req.index == OFF_WRAP && wdat[WRAP_FLAG_BIT])) | wrap;
        end
    end

    // Channel value registers
    genvar g;
    generate
        for (g = 0; g < CH; g++)
        begin : g_ch
            always_ff @(posedge core_clk)
            begin
                if (!rst_b)
                    channel_value[g] <= COUNT_RESET;
                else if (cap_edge[g])
                    channel_value[g] <= free_running_count;
                else if (wr && channel_mode_bits[g] && req.index == OFF_CHAN_BASE + 8'(g))
                    channel_value[g] <= wword;
            end
        end
    endgenerate

    // Pins and accumulator tick
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            comp_out <= BYTE_RESET;
            pin_prev <= BYTE_RESET;
            timer_port_out <= BYTE_RESET;
            timer_port_oe <= BYTE_RESET;
            acc_tick <= 1'b0;
        end
        else
        begin
            comp_out <= next_comp_out;
            pin_prev <= timer_port_in;
            timer_port_out <= next_pin;
            timer_port_oe <= next_oe;
            acc_tick <= timer_on && acc_div == ACC_DIV_LAST;
        end
    end
endmodule // timer_capture_compare_core

// *** testbench/timer_core_checker_assertions.sv ***
// Checker for the timer core: bus answer, pin enables and divided tick.
// Sees only the core's ports; bound from the bench top.
`timescale 1ns/10ps
module timer_core_checker
    import tim_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pins and tick
    input wire logic [7:0] timer_port_out,
    input wire logic [7:0] timer_port_oe,
    input wire logic acc_tick
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic [3:0] wr_hist;
    wire taken = hsel && hready && htrans[1];
    wire rd_force = taken && !hwrite && haddr[9:2] == OFF_FORCE;
    wire rd_byte = taken && !hwrite && haddr[9:4] == 6'h20 && haddr[9:2] != OFF_COUNT;
    // Pin enables come only from register state, so a change needs a recent write
    always_ff @(posedge core_clk)
        wr_hist <= rst_b ? {wr_hist[2:0], taken && hwrite} : 4'h0;
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("bus response not okay");
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("wait state inserted");
    property p_force_zero; rd_force |=> hrdata == 32'h0; endproperty
    a_force_zero: assert property (p_force_zero) else $error("force reads nonzero");
    property p_byte_wide; rd_byte |=> hrdata[31:8] == 24'h0; endproperty
    a_byte_wide: assert property (p_byte_wide) else $error("byte register too wide");
    property p_rst_clear;
        $rose(rst_b) |-> timer_port_oe == 8'h00 && timer_port_out == 8'h00 && !acc_tick;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared");
    property p_quiet_start; $rose(rst_b) |-> !acc_tick [*8]; endproperty
    a_quiet_start: assert property (p_quiet_start) else $error("tick while off");
    property p_tick_gap; acc_tick |=> !acc_tick [*8]; endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
    property p_oe_cause; !$stable(timer_port_oe) |-> |wr_hist; endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("enable moved alone");
    cover property (rd_force);
    cover property (acc_tick);
    cover property (!$stable(timer_port_oe));
endmodule // timer_core_checker

// *** testbench/timer_pin_model.sv ***
// Timer port lines: each resolved from the core and an outside driver.
// Undriven lines float high through the port pull-ups, on out of reset.
`timescale 1ns/10ps
module timer_pin_model
    import tim_pkg::*;
(
    // From the core
    input wire logic [7:0] timer_port_out,
    input wire logic [7:0] timer_port_oe,
    // Outside driver and resolved level
    input wire tim_pkg::port_drive_t ext,
    output logic [7:0] pin_level
);
    always_comb
        for (int i = 0; i < 8; i++)
            pin_level[i] = timer_port_oe[i] ? timer_port_out[i]
                : ext.enable[i] ? ext.value[i] : 1'b1;
endmodule // timer_pin_model

// *** testbench/test_timer_capture_compare_core.sv ***
// Self-checking bench for the capture/compare timer core over AHB-Lite.
// Assumes one master, a zero-wait slave and the pin model on the port.
`timescale 1ns/10ps
module test_timer_capture_compare_core;
    import tim_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic special_mode_flag = 1'b0;
    port_drive_t ext = '0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, acc_tick;
    wire [7:0] port_in, port_out, port_oe;
    int err_count = 0;
    int n_tests = 0;
    logic [31:0] q;
    timer_capture_compare_core u_timer_capture_compare_core (.core_clk(core_clk),
        .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .special_mode_flag(special_mode_flag),
        .timer_port_in(port_in), .timer_port_out(port_out), .timer_port_oe(port_oe),
        .acc_tick(acc_tick));
    timer_pin_model u_timer_pin_model (.timer_port_out(port_out), .timer_port_oe(port_oe),
        .ext(ext), .pin_level(port_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask
    // One single transfer; read data lands in q
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic t_force_read;
        bus(1'b1, OFF_CHANNEL_MODE, 32'h5A);
        bus(1'b1, OFF_FORCE, 32'hFF);
        bus(1'b0, OFF_FORCE, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, OFF_CHANNEL_MODE, 32'h0);
        chk(q, 32'h5A);
    endtask
    task automatic t_codes;
        // Output code in the upper bits, expected pin level in bit 0
        logic [2:0] tab [4] = '{3'h7, 3'h2, 3'h3, 3'h4};
        bus(1'b1, OFF_CHANNEL_MODE, 32'h01);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, OFF_OUT_MODE, {31'h0, tab[i][2]});
            bus(1'b1, OFF_OUT_LEVEL, {31'h0, tab[i][1]});
            bus(1'b1, OFF_FORCE, 32'h01);
            repeat (3) @(posedge core_clk);
            chk({port_oe[0], port_in[0]}, {1'b1, tab[i][0]});
        end
        bus(1'b1, OFF_OUT_MODE, 32'h0);
        bus(1'b1, OFF_OUT_LEVEL, 32'h0);
        repeat (3) @(posedge core_clk);
        chk(port_oe, 8'h00);
        bus(1'b0, OFF_FLAGS, 32'h0);
        chk(q, 32'h0);
    endtask
    task automatic t_gpio;
        bus(1'b1, OFF_DIRECTION, 32'h02);
        bus(1'b1, OFF_PORT, 32'h02);
        repeat (3) @(posedge core_clk);
        chk({port_oe[1], port_in[1]}, 2'h3);
        bus(1'b1, OFF_DIRECTION, 32'h0);
    endtask
    // Channel 3 drives high, channel 7 data low on the same count
    task automatic t_ch7;
        bus(1'b1, OFF_CHANNEL_MODE, 32'h88);
        bus(1'b1, OFF_OUT_MODE, 32'h08);
        bus(1'b1, OFF_OUT_LEVEL, 32'h08);
        bus(1'b1, OFF_CH7_MASK, 32'h08);
        bus(1'b1, OFF_CH7_DATA, 32'h00);
        bus(1'b1, OFF_CHAN_BASE + 8'h3, 32'h0010);
        bus(1'b1, OFF_CHAN_BASE + 8'h7, 32'h0010);
        bus(1'b1, OFF_COUNT, 32'h0);
        bus(1'b1, OFF_FORCE, 32'h08);
        repeat (3) @(posedge core_clk);
        chk(port_in[3], 1'b1);
        bus(1'b1, OFF_CONTROL, 32'h80);
        repeat (40) @(posedge core_clk);
        chk({port_oe[3], port_in[3]}, 2'h2);
        bus(1'b1, OFF_PORT, 32'h08);
        repeat (3) @(posedge core_clk);
        chk(port_in[3], 1'b0);
        bus(1'b1, OFF_DIRECTION, 32'h08);
        bus(1'b1, OFF_CH7_MASK, 32'h00);
        bus(1'b1, OFF_OUT_MODE, 32'h00);
        bus(1'b1, OFF_OUT_LEVEL, 32'h00);
        repeat (3) @(posedge core_clk);
        chk({port_oe[3], port_out[3]}, 2'h3);
        bus(1'b1, OFF_DIRECTION, 32'h00);
    endtask
    task automatic t_tick;
        int n;
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            repeat (192)
            begin
                @(posedge core_clk);
                n += int'(acc_tick === 1'b1);
            end
            chk(n, k ? 0 : 3);
            bus(1'b1, OFF_CONTROL, 32'h0);
            @(posedge core_clk);
        end
    endtask
    task automatic test_done;
        if (err_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        chk({hresp, acc_tick, port_oe, port_out}, 18'h0);
        t_force_read();
        t_codes();
        t_gpio();
        t_ch7();
        t_tick();
        test_done();
    end
    initial
    begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        test_done();
    end
endmodule // test_timer_capture_compare_core
bind timer_capture_compare_core timer_core_checker u_timer_core_checker (.core_clk(core_clk),
    .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_port_out(timer_port_out), .timer_port_oe(timer_port_oe), .acc_tick(acc_tick));
